// file: verilog/lcd_ext_cfg.svh
// Constants of the LCD panel extension register bank
`ifndef LCD_EXT_CFG_SVH
`define LCD_EXT_CFG_SVH

// Register indices, sequencer data port
`define LX_IDX_GRAY_OFFSET 8'hD6
`define LX_IDX_MOD_HALF 8'hD9
`define LX_IDX_BORDER 8'hDA
`define LX_IDX_PANEL_CTL3 8'hDB
// Register indices, CRT controller data port
`define LX_IDX_START_HIGH 8'h26
`define LX_IDX_CURSOR_HIGH 8'h27

// Field positions
`define LX_GRAY_STIPPLE_BIT 7
`define LX_GRAY_OFS_MSB 3
`define LX_BORDER_MSB 3
`define LX_CTL3_CGA_BIT 7
`define LX_CTL3_MCLK_INV_BIT 6
`define LX_CTL3_TRISTATE_BIT 5
`define LX_ADDR_HIGH_MSB 1

// Reset values
`define LX_RST_GRAY_OFS 4'hD
`define LX_RST_STIPPLE 1'b0
`define LX_RST_MOD_HALF 8'h00
`define LX_RST_BORDER 4'h0
`define LX_RST_CTL3 3'h0
`define LX_RST_ADDR_HIGH 2'h0

`endif

// file: verilog/lcd_ext_pkg.sv
// Types shared by the LCD panel extension register bank
package lcd_ext_pkg;
  typedef logic [7:0] index_t;
  typedef logic [3:0] shade_t;
  typedef logic [1:0] addr_high_t;
endpackage : lcd_ext_pkg

// file: verilog/ac_invert_counter.sv
// Line-clock counter that makes the panel AC inversion square wave
`timescale 1ns/100ps
module ac_invert_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic line_pulse_i,
  input wire logic [WIDTH-1:0] half_period_i,
  output logic ac_invert_o
);
  logic [WIDTH-1:0] count;
  wire [WIDTH:0] count_inc = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};
  wire half_zero = (half_period_i == '0);
  wire reach = line_pulse_i && !half_zero && (count_inc >= {1'b0, half_period_i});

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count <= '0;
      ac_invert_o <= 1'b0;
    end
    else if (reach)
    begin
      count <= '0;
      ac_invert_o <= !ac_invert_o;
    end
    else if (line_pulse_i && !half_zero)
    begin
      count <= count_inc[WIDTH-1:0];
    end
  end
endmodule : ac_invert_counter

// file: verilog/lcd_panel_extension_regs.sv
// LCD panel extension registers and the panel logic they steer
`timescale 1ns/100ps
`include "lcd_ext_cfg.svh"
module lcd_panel_extension_regs #(
  parameter int MOD_WIDTH = 8
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] SEQ_INDEX_I,
  input wire logic SEQ_WR_I,
  input wire logic SEQ_RD_I,
  input wire logic [7:0] CRTC_INDEX_I,
  input wire logic CRTC_WR_I,
  input wire logic CRTC_RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic LINE_CLK_I,
  input wire logic FIRST_LINE_I,
  input wire logic DISPLAY_ACTIVE_I,
  input wire logic [3:0] PIXEL_GRAY_I,
  input wire logic LCD_MODE_I,
  input wire logic TEXT_MODE_I,
  input wire logic REVERSE_VIDEO_I,
  input wire logic [7:0] PIXEL_DATA_I,
  input wire logic [1:0] FEATURE_PIN_I,
  input wire logic [15:0] START_LOW_I,
  input wire logic [15:0] CURSOR_LOW_I,
  output logic [7:0] RDATA_O,
  output logic RDATA_VALID_O,
  output logic [3:0] GRAY_PHASE_O,
  output logic VERT_STIPPLE_O,
  output logic AC_INVERT_O,
  output logic [3:0] PANEL_SHADE_O,
  output logic PALETTE_BYPASS_O,
  output logic MEM_CLK_INVERT_O,
  output logic [7:0] PIXEL_O,
  output logic [7:0] PIXEL_OE_O,
  output logic DOT_CLK_O,
  output logic DOT_CLK_OE_O,
  output logic [1:0] FEATURE_O,
  output logic [17:0] SCREEN_START_O,
  output logic [17:0] CURSOR_ADDR_O
);
  // Register storage, implemented bits only
  lcd_ext_pkg::shade_t gray_offset;
  logic stipple_en;
  logic [MOD_WIDTH-1:0] mod_half;
  lcd_ext_pkg::shade_t border;
  logic cga_select;
  logic mclk_invert;
  logic video_tristate;
  lcd_ext_pkg::addr_high_t start_high;
  lcd_ext_pkg::addr_high_t cursor_high;
  logic ac_invert;

  // Write decode
  wire wr_gray = SEQ_WR_I && (SEQ_INDEX_I == `LX_IDX_GRAY_OFFSET);
  wire wr_mod = SEQ_WR_I && (SEQ_INDEX_I == `LX_IDX_MOD_HALF);
  wire wr_border = SEQ_WR_I && (SEQ_INDEX_I == `LX_IDX_BORDER);
  wire wr_ctl3 = SEQ_WR_I && (SEQ_INDEX_I == `LX_IDX_PANEL_CTL3);
  wire wr_start = CRTC_WR_I && (CRTC_INDEX_I == `LX_IDX_START_HIGH);
  wire wr_cursor = CRTC_WR_I && (CRTC_INDEX_I == `LX_IDX_CURSOR_HIGH);

  // Read views, reserved bits forced to zero
  wire [7:0] view_gray = {stipple_en, 3'h0, gray_offset};
  wire [7:0] view_mod = mod_half;
  wire [7:0] view_border = {4'h0, border};
  wire [7:0] view_ctl3 = {cga_select, mclk_invert, video_tristate, 5'h00};
  wire [7:0] view_start = {6'h00, start_high};
  wire [7:0] view_cursor = {6'h00, cursor_high};

  wire [7:0] seq_rd_data =
    (SEQ_INDEX_I == `LX_IDX_GRAY_OFFSET) ? view_gray :
    (SEQ_INDEX_I == `LX_IDX_MOD_HALF) ? view_mod :
    (SEQ_INDEX_I == `LX_IDX_BORDER) ? view_border :
    (SEQ_INDEX_I == `LX_IDX_PANEL_CTL3) ? view_ctl3 : 8'h00;
  wire [7:0] crtc_rd_data =
    (CRTC_INDEX_I == `LX_IDX_START_HIGH) ? view_start :
    (CRTC_INDEX_I == `LX_IDX_CURSOR_HIGH) ? view_cursor : 8'h00;
  wire [7:0] next_rdata = SEQ_RD_I ? seq_rd_data : (CRTC_RD_I ? crtc_rd_data : 8'h00);

  // Gray wave start phase per line
  wire [4:0] gray_sum = {1'b0, GRAY_PHASE_O} + {1'b0, gray_offset};
  wire [3:0] next_gray_phase = FIRST_LINE_I ? 4'h0 : gray_sum[3:0];

  // Panel shade: reverse video acts on displayed image only
  wire reverse_on = LCD_MODE_I && TEXT_MODE_I && REVERSE_VIDEO_I;
  wire [3:0] image_shade = reverse_on ? ~PIXEL_GRAY_I : PIXEL_GRAY_I;
  wire [3:0] next_panel_shade = DISPLAY_ACTIVE_I ? image_shade : border;

  // Register writes
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      gray_offset <= `LX_RST_GRAY_OFS;
      stipple_en <= `LX_RST_STIPPLE;
      mod_half <= `LX_RST_MOD_HALF;
      border <= `LX_RST_BORDER;
      {cga_select, mclk_invert, video_tristate} <= `LX_RST_CTL3;
      start_high <= `LX_RST_ADDR_HIGH;
      cursor_high <= `LX_RST_ADDR_HIGH;
    end
    else
    begin
      if (wr_gray)
      begin
        gray_offset <= WDATA_I[`LX_GRAY_OFS_MSB:0];
        stipple_en <= WDATA_I[`LX_GRAY_STIPPLE_BIT];
      end
      if (wr_mod)
        mod_half <= WDATA_I[MOD_WIDTH-1:0];
      if (wr_border)
        border <= WDATA_I[`LX_BORDER_MSB:0];
      if (wr_ctl3)
      begin
        cga_select <= WDATA_I[`LX_CTL3_CGA_BIT];
        mclk_invert <= WDATA_I[`LX_CTL3_MCLK_INV_BIT];
        video_tristate <= WDATA_I[`LX_CTL3_TRISTATE_BIT];
      end
      if (wr_start)
        start_high <= WDATA_I[`LX_ADDR_HIGH_MSB:0];
      if (wr_cursor)
        cursor_high <= WDATA_I[`LX_ADDR_HIGH_MSB:0];
    end
  end

  // Read answer
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      RDATA_O <= 8'h00;
      RDATA_VALID_O <= 1'b0;
    end
    else
    begin
      RDATA_O <= next_rdata;
      RDATA_VALID_O <= SEQ_RD_I || CRTC_RD_I;
    end
  end

  // Gray wave phase advances once per line clock
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      GRAY_PHASE_O <= 4'h0;
    else if (LINE_CLK_I)
      GRAY_PHASE_O <= next_gray_phase;
  end

  // Panel-facing outputs
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      VERT_STIPPLE_O <= 1'b0;
      PANEL_SHADE_O <= 4'h0;
      PALETTE_BYPASS_O <= 1'b0;
      MEM_CLK_INVERT_O <= 1'b0;
      PIXEL_O <= 8'h00;
      PIXEL_OE_O <= 8'h00;
      DOT_CLK_O <= 1'b0;
      DOT_CLK_OE_O <= 1'b0;
      FEATURE_O <= 2'h0;
      SCREEN_START_O <= 18'h0_0000;
      CURSOR_ADDR_O <= 18'h0_0000;
      AC_INVERT_O <= 1'b0;
    end
    else
    begin
      VERT_STIPPLE_O <= stipple_en;
      PANEL_SHADE_O <= next_panel_shade;
      PALETTE_BYPASS_O <= LCD_MODE_I && cga_select;
      MEM_CLK_INVERT_O <= mclk_invert;
      PIXEL_O <= PIXEL_DATA_I;
      PIXEL_OE_O <= {8{!video_tristate}};
      DOT_CLK_O <= !DOT_CLK_O;
      DOT_CLK_OE_O <= !video_tristate;
      FEATURE_O <= FEATURE_PIN_I;
      SCREEN_START_O <= {start_high, START_LOW_I};
      CURSOR_ADDR_O <= {cursor_high, CURSOR_LOW_I};
      AC_INVERT_O <= ac_invert;
    end
  end

  // AC inversion wave, counted on line clocks
  ac_invert_counter #(
    .WIDTH(MOD_WIDTH)
  ) u_ac_counter (
    .clk_i(MCLK_I),
    .reset_i(RESET_I),
    .line_pulse_i(LINE_CLK_I),
    .half_period_i(mod_half),
    .ac_invert_o(ac_invert)
  );

  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  gray_reset_val_a: assert property ($past(RESET_I) |-> gray_offset == 4'hD)
    else $error("gray offset not thirteen after reset");
  gray_line_shift_a: assert property (LINE_CLK_I && !FIRST_LINE_I |=>
    GRAY_PHASE_O == 4'(($past(GRAY_PHASE_O) + $past(gray_offset)) & 5'h0F))
    else $error("gray phase did not advance by offset");
  gray_first_line_a: assert property (LINE_CLK_I && FIRST_LINE_I |=> GRAY_PHASE_O == 4'h0)
    else $error("first line gray phase not zero");
  stipple_follow_a: assert property (wr_gray |=> ##1 VERT_STIPPLE_O == $past(WDATA_I[7], 2))
    else $error("stipple output does not follow bit 7");
  ac_toggle_cause_a: assert property ($changed(ac_invert) |-> $past(LINE_CLK_I))
    else $error("AC inversion changed without a line clock");
  ac_half_period_a: assert property (mod_half == 8'h01 && LINE_CLK_I && !wr_mod |=>
    ac_invert != $past(ac_invert))
    else $error("AC inversion missed toggle at half period one");
  border_shade_a: assert property (!DISPLAY_ACTIVE_I |=> PANEL_SHADE_O == $past(border))
    else $error("border shade wrong outside display");
  reverse_text_a: assert property (DISPLAY_ACTIVE_I && reverse_on |=>
    PANEL_SHADE_O == ~$past(PIXEL_GRAY_I))
    else $error("reverse video not applied");
  palette_bypass_a: assert property (LCD_MODE_I && cga_select |=> PALETTE_BYPASS_O)
    else $error("palette not bypassed");
  mclk_invert_a: assert property (wr_ctl3 |=> ##1 MEM_CLK_INVERT_O == $past(WDATA_I[6], 2))
    else $error("memory clock invert not applied");
  tristate_pins_a: assert property (video_tristate |=> PIXEL_OE_O == 8'h00 && !DOT_CLK_OE_O)
    else $error("pixel pins driven while tristated");
  start_high_a: assert property (wr_start |=> ##1 SCREEN_START_O[17:16] == $past(WDATA_I[1:0], 2))
    else $error("screen start high bits wrong");
  cursor_high_a: assert property (wr_cursor |=> ##1 CURSOR_ADDR_O[17:16] == $past(WDATA_I[1:0], 2))
    else $error("cursor high bits wrong");
  reserved_zero_a: assert property (SEQ_RD_I && SEQ_INDEX_I == `LX_IDX_GRAY_OFFSET |=>
    RDATA_VALID_O && RDATA_O[6:4] == 3'h0)
    else $error("reserved bits read nonzero");

  // Register fields take written data and hold without a write
  gray_write_a: assert property (wr_gray |=>
    gray_offset == $past(WDATA_I[`LX_GRAY_OFS_MSB:0]))
    else $error("gray offset write lost");
  border_write_a: assert property (wr_border |=>
    border == $past(WDATA_I[`LX_BORDER_MSB:0]))
    else $error("border shade write lost");
  mod_write_a: assert property (wr_mod |=>
    mod_half == $past(WDATA_I[MOD_WIDTH-1:0]))
    else $error("half period write lost");
  cga_write_a: assert property (wr_ctl3 |=>
    cga_select == $past(WDATA_I[`LX_CTL3_CGA_BIT]))
    else $error("palette select write lost");
  tristate_write_a: assert property (wr_ctl3 |=>
    video_tristate == $past(WDATA_I[`LX_CTL3_TRISTATE_BIT]))
    else $error("tristate write lost");
  start_keep_a: assert property (!wr_start |=>
    $stable(start_high))
    else $error("screen start high changed without a write");
  cursor_keep_a: assert property (!wr_cursor |=>
    $stable(cursor_high))
    else $error("cursor high changed without a write");

  // Panel outputs follow the fields
  gray_hold_a: assert property (!LINE_CLK_I |=>
    $stable(GRAY_PHASE_O))
    else $error("gray phase moved without a line clock");
  stipple_off_a: assert property (!stipple_en |=>
    !VERT_STIPPLE_O)
    else $error("stipple output set while disabled");
  ac_frozen_a: assert property (mod_half == '0 |=>
    $stable(ac_invert))
    else $error("AC inversion moved with half period zero");
  ac_output_a: assert property (!$past(RESET_I) |->
    AC_INVERT_O == $past(ac_invert))
    else $error("AC inversion output does not follow the counter");
  image_shade_a: assert property (DISPLAY_ACTIVE_I &&
    !(LCD_MODE_I && TEXT_MODE_I && REVERSE_VIDEO_I) |=> PANEL_SHADE_O == $past(PIXEL_GRAY_I))
    else $error("image shade altered without reverse video");
  palette_through_a: assert property (!(LCD_MODE_I && cga_select) |=>
    !PALETTE_BYPASS_O)
    else $error("palette bypassed outside CGA LCD mode");
  mclk_plain_a: assert property (!mclk_invert |=>
    !MEM_CLK_INVERT_O)
    else $error("memory clock inverted while bit clear");
  pins_driven_a: assert property (!video_tristate |=>
    PIXEL_OE_O == 8'hFF && DOT_CLK_OE_O)
    else $error("pixel pins released while enabled");
  pixel_copy_a: assert property (1'b1 |=>
    PIXEL_O == $past(PIXEL_DATA_I))
    else $error("pixel outputs do not follow pixel data");
  dot_clock_run_a: assert property (!$past(RESET_I) |->
    DOT_CLK_O != $past(DOT_CLK_O))
    else $error("dot clock stopped");
  start_low_a: assert property (1'b1 |=>
    SCREEN_START_O[15:0] == $past(START_LOW_I))
    else $error("screen start low bits wrong");
  cursor_low_a: assert property (1'b1 |=>
    CURSOR_ADDR_O[15:0] == $past(CURSOR_LOW_I))
    else $error("cursor low bits wrong");

  // Read port answers
  read_valid_a: assert property (SEQ_RD_I || CRTC_RD_I |=>
    RDATA_VALID_O)
    else $error("read not answered");
  idle_read_a: assert property (!SEQ_RD_I && !CRTC_RD_I |=>
    !RDATA_VALID_O && RDATA_O == 8'h00)
    else $error("read port busy without a read");
  border_reserved_a: assert property (SEQ_RD_I && SEQ_INDEX_I == `LX_IDX_BORDER |=>
    RDATA_O[7:4] == 4'h0)
    else $error("border reserved bits read nonzero");
  ctl3_reserved_a: assert property (SEQ_RD_I && SEQ_INDEX_I == `LX_IDX_PANEL_CTL3 |=>
    RDATA_O[4:0] == 5'h00)
    else $error("control reserved bits read nonzero");
  high_reserved_a: assert property (CRTC_RD_I && !SEQ_RD_I |=>
    RDATA_O[7:2] == 6'h00)
    else $error("address high unused bits read nonzero");
  mod_readback_a: assert property (SEQ_RD_I && SEQ_INDEX_I == `LX_IDX_MOD_HALF |=>
    RDATA_O == $past(mod_half))
    else $error("half period reads back wrong");

  ac_toggle_c: cover property ($rose(ac_invert));
  border_shown_c: cover property (!DISPLAY_ACTIVE_I && border == 4'hF);
  tristate_c: cover property (wr_ctl3 && WDATA_I[5]);
  first_line_c: cover property (LINE_CLK_I && FIRST_LINE_I ##[1:20] LINE_CLK_I && !FIRST_LINE_I);
  half_one_c: cover property (mod_half == 8'h01 && LINE_CLK_I);
endmodule : lcd_panel_extension_regs

// file: tb/lcd_panel_model.sv
// Flat panel model that resolves the pixel and dot clock pins
`timescale 1ns/100ps
module lcd_panel_model #(
  parameter logic [7:0] PULL_LEVEL = 8'hFF
) (
  input wire logic [7:0] pixel_i,
  input wire logic [7:0] pixel_oe_i,
  input wire logic dot_clk_i,
  input wire logic dot_clk_oe_i,
  output logic [7:0] pin_level_o,
  output logic [1:0] feature_o,
  output logic dot_level_o
);
  // Released pins fall back to the panel pull-ups
  assign pin_level_o = (pixel_i & pixel_oe_i) | (PULL_LEVEL & ~pixel_oe_i);
  assign feature_o = pin_level_o[7:6];
  assign dot_level_o = dot_clk_oe_i ? dot_clk_i : 1'b1;
endmodule : lcd_panel_model

// file: tb/lcd_panel_extension_regs_bench.sv
// Self-checking bench for the LCD panel extension registers
`timescale 1ns/100ps
module lcd_panel_extension_regs_bench;
  logic clk = 1'b0, rst = 1'b1;
  logic seq_wr = 1'b0, seq_rd = 1'b0, crtc_wr = 1'b0, crtc_rd = 1'b0;
  logic line_clk = 1'b0, first_line = 1'b0, disp_act = 1'b0;
  logic lcd_mode = 1'b1, text_mode = 1'b1, rev_video = 1'b1;
  logic [7:0] seq_idx = 8'h00, crtc_idx = 8'h00, wdata = 8'h00, pix_data = 8'hA5;
  logic [3:0] pix_gray = 4'h3;
  logic [15:0] start_low = 16'h1234, cursor_low = 16'hABCD;
  logic [1:0] feat_pins, feature;
  logic [7:0] rdata, pixel, pixel_oe, pins;
  logic rvalid, stipple, ac_inv, bypass, mclk_inv, dot_clk, dot_oe, dot_level, dot_prev;
  logic [3:0] gray_phase, shade, ph;
  logic [17:0] screen_start, cursor_addr;
  int bad_count = 0, checked = 0, cycles = 0;
  // Register rows: port, index, write data, reset read, read after write
  localparam logic [32:0] ROWS [8] = '{
    {1'b1, 8'hD6, 8'hFF, 8'h0D, 8'h8F}, {1'b1, 8'hD9, 8'h5A, 8'h00, 8'h5A},
    {1'b1, 8'hDA, 8'hFF, 8'h00, 8'h0F}, {1'b1, 8'hDB, 8'hFF, 8'h00, 8'hE0},
    {1'b0, 8'h26, 8'hFF, 8'h00, 8'h03}, {1'b0, 8'h27, 8'hFE, 8'h00, 8'h02},
    {1'b1, 8'hD7, 8'hFF, 8'h00, 8'h00}, {1'b0, 8'h28, 8'hFF, 8'h00, 8'h00}};
  localparam logic [7:0] HALVES [3] = '{8'h01, 8'h02, 8'h0D};

  lcd_panel_extension_regs dut (.MCLK_I(clk), .RESET_I(rst), .SEQ_INDEX_I(seq_idx),
    .SEQ_WR_I(seq_wr), .SEQ_RD_I(seq_rd), .CRTC_INDEX_I(crtc_idx), .CRTC_WR_I(crtc_wr),
    .CRTC_RD_I(crtc_rd), .WDATA_I(wdata), .LINE_CLK_I(line_clk), .FIRST_LINE_I(first_line),
    .DISPLAY_ACTIVE_I(disp_act), .PIXEL_GRAY_I(pix_gray), .LCD_MODE_I(lcd_mode),
    .TEXT_MODE_I(text_mode), .REVERSE_VIDEO_I(rev_video), .PIXEL_DATA_I(pix_data),
    .FEATURE_PIN_I(feat_pins), .START_LOW_I(start_low), .CURSOR_LOW_I(cursor_low),
    .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .GRAY_PHASE_O(gray_phase),
    .VERT_STIPPLE_O(stipple), .AC_INVERT_O(ac_inv), .PANEL_SHADE_O(shade),
    .PALETTE_BYPASS_O(bypass), .MEM_CLK_INVERT_O(mclk_inv), .PIXEL_O(pixel),
    .PIXEL_OE_O(pixel_oe), .DOT_CLK_O(dot_clk), .DOT_CLK_OE_O(dot_oe),
    .FEATURE_O(feature), .SCREEN_START_O(screen_start), .CURSOR_ADDR_O(cursor_addr));

  lcd_panel_model panel (.pixel_i(pixel), .pixel_oe_i(pixel_oe), .dot_clk_i(dot_clk),
    .dot_clk_oe_i(dot_oe), .pin_level_o(pins), .feature_o(feat_pins), .dot_level_o(dot_level));

  always #50 clk = ~clk;

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic seq, input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk);
    seq_idx <= idx;
    crtc_idx <= idx;
    wdata <= data;
    seq_wr <= seq;
    crtc_wr <= !seq;
    @(posedge clk);
    seq_wr <= 1'b0;
    crtc_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic seq, input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clk);
    seq_idx <= idx;
    crtc_idx <= idx;
    seq_rd <= seq;
    crtc_rd <= !seq;
    @(posedge clk);
    seq_rd <= 1'b0;
    crtc_rd <= 1'b0;
    #10;
    chk(rvalid, 1);
    chk(rdata, exp);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk);
    #10;
  endtask : settle

  task automatic pulse(input logic first);
    @(posedge clk);
    line_clk <= 1'b1;
    first_line <= first;
    @(posedge clk);
    line_clk <= 1'b0;
    first_line <= 1'b0;
    #10;
  endtask : pulse

  task automatic do_reset;
    rst <= 1'b1;
    @(posedge clk);
    #10;
    chk(pixel_oe, 0);
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  initial
  begin
    do_reset();
    foreach (ROWS[i])
    begin
      rd(ROWS[i][32], ROWS[i][31:24], ROWS[i][15:8]);
      wr(ROWS[i][32], ROWS[i][31:24], ROWS[i][23:16]);
      rd(ROWS[i][32], ROWS[i][31:24], ROWS[i][7:0]);
    end
    settle();
    chk(stipple, 1);
    chk(bypass, 1);
    chk(mclk_inv, 1);
    chk({pixel_oe, dot_oe, feature}, {8'h00, 1'b0, 2'b11});
    chk({pins, dot_level}, {8'hFF, 1'b1});
    chk(shade, 4'hF);
    chk(screen_start, 18'h3_1234);
    chk(cursor_addr, 18'h2_ABCD);
    @(posedge clk);
    disp_act <= 1'b1;
    settle();
    chk(shade, 4'hC);
    @(posedge clk);
    lcd_mode <= 1'b0;
    settle();
    chk({bypass, shade}, {1'b0, 4'h3});
    @(posedge clk);
    lcd_mode <= 1'b1;
    text_mode <= 1'b0;
    settle();
    chk(shade, 4'h3);
    wr(1'b1, 8'hDB, 8'h00);
    wr(1'b1, 8'hDA, 8'h00);
    disp_act <= 1'b0;
    lcd_mode <= 1'b1;
    settle();
    chk({pixel_oe, dot_oe, feature, mclk_inv}, {8'hFF, 1'b1, 2'b10, 1'b0});
    chk(shade, 4'h0);
    chk(pins, 8'hA5);
    dot_prev = dot_level;
    @(posedge clk);
    #10;
    chk(dot_level ^ dot_prev, 1'b1);
    wr(1'b1, 8'hD6, 8'h05);
    pulse(1'b1);
    chk(gray_phase, 4'h0);
    ph = 4'h0;
    for (int k = 1; k <= 4; k++)
    begin
      pulse(1'b0);
      ph = ph + 4'h5;
      chk(gray_phase, ph);
    end
    foreach (HALVES[h])
    begin
      @(posedge clk);
      do_reset();
      wr(1'b1, 8'hD9, HALVES[h]);
      settle();
      chk(ac_inv, 0);
      for (int k = 1; k <= 2 * HALVES[h]; k++)
      begin
        pulse(1'b0);
        settle();
        chk(ac_inv, (k / HALVES[h]) % 2);
      end
    end
    wrap_up();
  end
endmodule : lcd_panel_extension_regs_bench
